// File: rtl/iwa_pkg.sv
package iwa_pkg;
	// Serial clocks in the data part of a byte, and the acknowledge clock.
	localparam int unsigned BYTE_CLOCKS = 8;
	localparam int unsigned ACK_CLOCK = 9;
	localparam int unsigned CNT_W = 4;
	localparam logic [3:0] CNT_BYTE = 4'h8;
	localparam logic [3:0] CNT_ACK = 4'h9;
	localparam logic [3:0] CNT_RST = 4'h0;
	// Upper four address bits that mark an extension code.
	localparam logic [3:0] EXT_CODE_PREFIX = 4'h0;
	localparam int unsigned EXT_PREFIX_LSB = 4;
	localparam int unsigned ADDR_W = 7;
	// Reset values of the configuration and tracking state.
	localparam logic WPS_RST = 1'b0;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [1:0] SYNC_RST = 2'h3;
	typedef enum logic {
		IWA_RUN,
		IWA_WAIT
	} iwa_state_e;
endpackage

// File: rtl/iwa_line_sync.sv
module iwa_line_sync #(
	parameter int unsigned WIDTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] line_i,
	output logic [WIDTH-1:0] line_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	// Lines idle high, so every stage resets to one to avoid false edges.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_line
			logic meta;
			logic stable;
			logic prev;
			always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					meta <= 1'b1;
					stable <= 1'b1;
					prev <= 1'b1;
				end else begin
					meta <= line_i[g];
					stable <= meta;
					prev <= stable;
				end
			end
			assign line_o[g] = stable;
			assign rise_o[g] = stable & ~prev;
			assign fall_o[g] = ~stable & prev;
		end
	endgenerate
endmodule

// File: rtl/iwa_wait_ack.sv
// Summary of operation
// [RULE_01] Select at 0: data byte interrupt at eighth clock falling edge.
// [RULE_02] Master, select at 0: hold clock low after eight clocks, wait.
// [RULE_03] Slave, select at 0: pull clock low after eight clocks, wait.
// [RULE_04] Slave, select at 1: hold clock low at the wait point too.
// [RULE_05] Select at 1: interrupt and wait at ninth falling edge.
// [RULE_06] Address byte always interrupts at the ninth falling edge; the code only when master, matched or extension.
// [RULE_07] Select setting applies only after the address transfer.
// [RULE_08] Master waits at ninth falling edge of the address byte.
// [RULE_09] Addressed slave waits after giving its acknowledge.
// [RULE_10] Slave receiving an extension code waits at eighth falling edge.
// [RULE_11] Select bit cleared by reset or write 0, set by write 1.
// [RULE_12] Ack enable 1 drives data low in ninth clock; 0 drives none.
// [RULE_13] Ack enable also governs acknowledging an extension code.
// [RULE_14] Software expecting an extension code sets ack enable.
// [RULE_15] Release trigger ends wait, frees clock, then clears itself.
module iwa_wait_ack (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic serial_clock_line_i,
	input wire logic serial_data_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_n_o,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_n_o,
	input wire logic wait_point_select_wr_i,
	input wire logic wait_point_select_data_i,
	output logic wait_point_select_o,
	input wire logic ack_drive_enable_i,
	input wire logic wait_release_trigger_i,
	input wire logic master_mode_i,
	input wire logic receiving_i,
	input wire logic [iwa_pkg::ADDR_W-1:0] own_addr_i,
	output logic xfer_irq_o,
	output logic wait_o,
	output logic addr_match_o,
	output logic ext_code_o
);
	import iwa_pkg::*;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;

	iwa_line_sync #(
		.WIDTH(2)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.line_i({serial_data_line_i, serial_clock_line_i}),
		.line_o({sda_s, scl_s}),
		.rise_o({sda_rise, scl_rise}),
		.fall_o({sda_fall, scl_fall})
	);

	iwa_state_e state;
	iwa_state_e next_state;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] next_bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic addr_phase;
	logic next_addr_phase;
	logic selected;
	logic next_selected;
	logic matched;
	logic next_matched;
	logic ext_code;
	logic next_ext_code;
	logic wps;
	logic next_wps;
	logic wrel;
	logic next_wrel;
	logic irq;
	logic next_irq;
	logic ack_drv;
	logic next_ack_drv;

	logic start_det;
	logic stop_det;
	logic fall8;
	logic fall9;
	logic addr_hit;
	logic ext_hit;
	logic wait_evt;

	assign start_det = sda_fall & scl_s;
	assign stop_det = sda_rise & scl_s;
	assign fall8 = scl_fall & (bit_cnt == CNT_BYTE);
	assign fall9 = scl_fall & (bit_cnt == CNT_ACK);
	assign addr_hit = ~master_mode_i && (shift[7:1] == own_addr_i);
	assign ext_hit = ~master_mode_i
		&& (shift[7:EXT_PREFIX_LSB] == EXT_CODE_PREFIX);

	always_comb begin
		next_wps = wps;
		if (wait_point_select_wr_i) begin
			next_wps = wait_point_select_data_i; // [RULE_11]
		end
		next_wrel = wait_release_trigger_i; // [RULE_15]
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_addr_phase = addr_phase;
		next_selected = selected;
		next_matched = matched;
		next_ext_code = ext_code;
		next_ack_drv = ack_drv;
		next_irq = 1'b0;
		wait_evt = 1'b0;
		if (start_det || stop_det) begin
			next_bit_cnt = CNT_RST;
			next_addr_phase = start_det;
			next_selected = start_det & master_mode_i;
			next_matched = 1'b0;
			next_ext_code = 1'b0;
			next_ack_drv = 1'b0;
		end else begin
			if (scl_rise && bit_cnt < CNT_ACK) begin
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt < CNT_BYTE) begin
					next_shift = {shift[6:0], sda_s};
				end
			end
			if (fall8) begin
				if (addr_phase) begin
					next_matched = addr_hit;
					next_ext_code = ext_hit & ~addr_hit;
					next_selected = master_mode_i | addr_hit | ext_hit;
					// Extension codes use the same enable as addresses.
					next_ack_drv = ack_drive_enable_i
						& (addr_hit | ext_hit); // [RULE_12] [RULE_13]
					wait_evt = ext_hit & ~addr_hit; // [RULE_10]
				end else begin
					next_ack_drv = ack_drive_enable_i
						& selected & receiving_i; // [RULE_12]
					// Data bytes only: the address byte ignores the select.
					if (selected && !wps) begin // [RULE_07]
						next_irq = 1'b1; // [RULE_01]
						wait_evt = 1'b1; // [RULE_02] [RULE_03]
					end
				end
			end
			if (fall9) begin
				next_bit_cnt = CNT_RST;
				next_ack_drv = 1'b0;
				next_addr_phase = 1'b0;
				if (addr_phase) begin
					next_irq = selected; // [RULE_06]
					wait_evt = master_mode_i | matched; // [RULE_08] [RULE_09]
				end else if (selected && wps) begin
					next_irq = 1'b1; // [RULE_05]
					wait_evt = 1'b1; // [RULE_04] [RULE_05]
				end
			end
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			IWA_RUN: begin
				if (wait_evt) begin
					next_state = IWA_WAIT;
				end
			end
			IWA_WAIT: begin
				// A stop ends the transfer, so no wait may outlive it.
				if (wrel || stop_det) begin
					next_state = IWA_RUN; // [RULE_15]
				end
			end
			default: begin
				next_state = IWA_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= IWA_RUN;
			bit_cnt <= CNT_RST;
			shift <= SHIFT_RST;
			addr_phase <= 1'b0;
			selected <= 1'b0;
			matched <= 1'b0;
			ext_code <= 1'b0;
			wps <= WPS_RST;
			wrel <= 1'b0;
			irq <= 1'b0;
			ack_drv <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			addr_phase <= next_addr_phase;
			selected <= next_selected;
			matched <= next_matched;
			ext_code <= next_ext_code;
			wps <= next_wps;
			wrel <= next_wrel;
			irq <= next_irq;
			ack_drv <= next_ack_drv;
		end
	end

	// Both pins are open drain: only a low level is ever driven.
	assign serial_clock_line_o = 1'b0;
	assign serial_clock_line_oe_n_o = (state != IWA_WAIT);
	assign serial_data_line_o = 1'b0;
	assign serial_data_line_oe_n_o = ~ack_drv;
	assign wait_point_select_o = wps;
	assign xfer_irq_o = irq;
	assign wait_o = (state == IWA_WAIT);
	assign addr_match_o = matched;
	assign ext_code_o = ext_code;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence data_fall8_s;
		fall8 && !addr_phase && selected && !start_det && !stop_det;
	endsequence
	sequence data_fall9_s;
		fall9 && !addr_phase && selected && !start_det && !stop_det;
	endsequence

	irq_at_eighth_a: assert property ( // [RULE_01]
		data_fall8_s and !wps |=> irq)
		else $error("no interrupt at eighth falling edge");
	wait_at_eighth_a: assert property ( // [RULE_02]
		data_fall8_s and !wps |=> ##1 !serial_clock_line_oe_n_o)
		else $error("clock not held after eight clocks");
	no_late_irq_a: assert property ( // [RULE_07]
		data_fall9_s and !wps |=> !irq)
		else $error("ninth edge interrupt with select at zero");
	irq_at_ninth_a: assert property ( // [RULE_05]
		data_fall9_s and wps |=> irq ##1 wait_o)
		else $error("no interrupt and wait at ninth edge");
	addr_irq_ninth_a: assert property ( // [RULE_06]
		fall9 && addr_phase && selected && !start_det && !stop_det
		|=> irq)
		else $error("address byte interrupt missing");
	master_addr_wait_a: assert property ( // [RULE_08]
		fall9 && addr_phase && master_mode_i && !start_det
		&& !stop_det && !wait_o |=> ##1 wait_o)
		else $error("master did not wait after address");
	wps_write_a: assert property ( // [RULE_11]
		wait_point_select_wr_i |=>
		wait_point_select_o == $past(wait_point_select_data_i))
		else $error("select bit write not taken");
	wps_hold_a: assert property ( // [RULE_11]
		!wait_point_select_wr_i |=> $stable(wait_point_select_o))
		else $error("select bit changed without write");
	ack_gate_a: assert property ( // [RULE_12]
		!serial_data_line_oe_n_o |-> $past(ack_drive_enable_i, 1)
		|| !$past(serial_data_line_oe_n_o))
		else $error("acknowledge driven while disabled");
	ack_end_a: assert property ( // [RULE_12]
		fall9 |=> serial_data_line_oe_n_o)
		else $error("acknowledge held past ninth clock");
	release_a: assert property ( // [RULE_15]
		wait_o && wait_release_trigger_i && !wait_evt
		|=> ##1 !wait_o && serial_clock_line_oe_n_o ##1 !wrel)
		else $error("release trigger did not end wait");
endmodule

// File: bench/iwa_bfm.sv
module iwa_bfm (
	input wire logic ref_clk_i,
	input wire logic dev_scl_oe_n_i,
	input wire logic dev_sda_oe_n_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_pull = 1'b0;
	logic sda_pull = 1'b0;
	// Both lines have pull-ups, so a line nobody pulls reads high.
	assign scl_o = !scl_pull && dev_scl_oe_n_i;
	assign sda_o = !sda_pull && dev_sda_oe_n_i;
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// A clock held low by the device is waited out, as any master must.
	task automatic clk_bit(input logic b, output logic seen);
		sda_pull = !b;
		hold(4);
		scl_pull = 1'b0;
		for (int i = 0; i < 4000 && !scl_o; i++)
			hold(1);
		hold(5);
		seen = sda_o;
		scl_pull = 1'b1;
		hold(8);
	endtask
	task automatic start_cond;
		sda_pull = 1'b0;
		hold(4);
		scl_pull = 1'b0;
		hold(6);
		sda_pull = 1'b1;
		hold(6);
		scl_pull = 1'b1;
		hold(6);
	endtask
	task automatic stop_cond;
		sda_pull = 1'b1;
		hold(4);
		scl_pull = 1'b0;
		hold(6);
		sda_pull = 1'b0;
		hold(6);
	endtask
	task automatic send_byte(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(v[i], s);
	endtask
endmodule

// File: bench/tb_i2c_wait_ack_control.sv
module tb_i2c_wait_ack_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel_wr = 1'b0;
	logic sel_d = 1'b0;
	logic ack_en = 1'b0;
	logic wrel = 1'b0;
	logic mst = 1'b0;
	logic [iwa_pkg::ADDR_W-1:0] own = 7'h2A;
	logic scl, sda, scl_oe_n, sda_oe_n, sel, irq, wt, match, ext, a;
	logic scl_do, sda_do;
	logic rcv = 1'b1;
	int err_total = 0;
	int total_checks = 0;
	int irqs = 0;
	int mark = 0;
	`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
		err_total++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
		end end
	initial begin
		forever #12.5 clk = ~clk;
	end
	// The request is a one-cycle pulse, so it is tallied as it passes.
	always @(negedge clk) if (irq === 1'b1) irqs++;
	iwa_wait_ack iwa_wait_ack_i (.ref_clk_i(clk), .reset_n_i(rst_n),
		.serial_clock_line_i(scl), .serial_data_line_i(sda),
		.serial_clock_line_o(scl_do), .serial_clock_line_oe_n_o(scl_oe_n),
		.serial_data_line_o(sda_do), .serial_data_line_oe_n_o(sda_oe_n),
		.wait_point_select_wr_i(sel_wr), .wait_point_select_data_i(sel_d),
		.wait_point_select_o(sel), .ack_drive_enable_i(ack_en),
		.wait_release_trigger_i(wrel), .master_mode_i(mst),
		.receiving_i(rcv), .own_addr_i(own), .xfer_irq_o(irq),
		.wait_o(wt), .addr_match_o(match), .ext_code_o(ext));
	iwa_bfm iwa_bfm_i (.ref_clk_i(clk), .dev_scl_oe_n_i(scl_oe_n),
		.dev_sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic st(input string n, input int di, input logic w);
		`CK({n, " irq"}, di, irqs - mark)
		`CK({n, " wait"}, w, wt)
		`CK({n, " scl drive"}, !w, scl_oe_n)
		`CK({n, " scl out"}, 1'b0, scl_do)
		mark = irqs;
	endtask
	task automatic rel;
		wrel = 1'b1;
		@(negedge clk);
		wrel = 1'b0;
		repeat (4) @(negedge clk);
		mark = irqs;
	endtask
	task automatic wsel(input logic v);
		sel_wr = 1'b1;
		sel_d = v;
		@(negedge clk);
		sel_wr = 1'b0;
		`CK("select", v, sel)
	endtask
	task automatic ack9(input logic e);
		iwa_bfm_i.clk_bit(1'b1, a);
		`CK("ack", e, a)
		`CK("sda out", 1'b0, sda_do)
	endtask
	task automatic t_addr;
		ack_en = 1'b1;
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'h54);
		st("a8", 0, 1'b0);
		ack9(1'b0);
		st("a9", 1, 1'b1);
		`CK("match", 1'b1, match)
		rel;
		st("rel", 0, 1'b0);
		iwa_bfm_i.send_byte(8'hC3);
		st("d8", 1, 1'b1);
		rel;
		ack9(1'b0);
		st("d9", 0, 1'b0);
		iwa_bfm_i.stop_cond;
		$display("test addr done");
	endtask
	task automatic t_sel1;
		wsel(1'b1);
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'h54);
		st("s8", 0, 1'b0);
		ack9(1'b0);
		st("s9", 1, 1'b1);
		rel;
		ack_en = 1'b0;
		iwa_bfm_i.send_byte(8'h5A);
		st("e8", 0, 1'b0);
		ack9(1'b1);
		st("e9", 1, 1'b1);
		rel;
		iwa_bfm_i.stop_cond;
		wsel(1'b0);
		$display("test sel1 done");
	endtask
	task automatic t_ext;
		ack_en = 1'b1;
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'h08);
		st("x8", 0, 1'b1);
		`CK("ext", 1'b1, ext)
		rel;
		ack9(1'b0);
		st("x9", 1, 1'b0);
		iwa_bfm_i.stop_cond;
		$display("test ext done");
	endtask
	task automatic t_other;
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'h66);
		ack9(1'b1);
		st("o9", 0, 1'b0);
		`CK("no match", 1'b0, match)
		iwa_bfm_i.stop_cond;
		// The same byte must now match, so the compare really uses the address.
		own = 7'h33;
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'h66);
		ack9(1'b0);
		st("n9", 1, 1'b1);
		`CK("match2", 1'b1, match)
		rel;
		iwa_bfm_i.stop_cond;
		own = 7'h2A;
		$display("test other done");
	endtask
	task automatic t_mst;
		mst = 1'b1;
		iwa_bfm_i.start_cond;
		iwa_bfm_i.send_byte(8'hA0);
		st("m8", 0, 1'b0);
		ack9(1'b1);
		st("m9", 1, 1'b1);
		rel;
		// A transmitting master must not acknowledge its own data byte.
		rcv = 1'b0;
		iwa_bfm_i.send_byte(8'h11);
		st("md8", 1, 1'b1);
		rel;
		ack9(1'b1);
		iwa_bfm_i.stop_cond;
		rcv = 1'b1;
		mst = 1'b0;
		$display("test master done");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		`CK("select rst", 1'b0, sel)
		repeat (3) @(negedge clk);
		t_addr;
		t_sel1;
		t_ext;
		t_other;
		t_mst;
		give_verdict;
	end
	initial begin
		#1_000_000;
		err_total++;
		give_verdict;
	end
endmodule
